// File: logic/ctp_timer_pair.sv
// cascadable pair of 16-bit timers with an avalon-mm register port
//
// The Avalon-MM register port and the address map are this design's own decisions.

// register map, one 32-bit word per register, 16-bit values in bits 15:0
//   00 lower timer control     04 upper timer control
//   08 lower count word        0C upper count word
//   10 lower period word       14 upper period word
//   18 upper count hold        1C interrupt status, write one to clear
//   20 interrupt mask          24 idle mode, bit 0
// control word layout, both timers
//   15 run, 13 idle stop, 6 gate accumulate, 5:4 prescale
//   3 pair mode (lower only), 1 clock source; all other bits read zero
// interrupt status bits
//   0 lower match alone, 1 upper match alone, 2 pair match
// bus timing
//   a request is taken at the edge where the slave is idle
//   waitrequest drops for the following cycle only
//   read data and the error flag are registered at the taking edge
//   a second request may follow straight after completion
// limitations
//   unaligned or unmapped addresses answer with the error flag and no effect
//   byte lanes 3:2 are ignored, no register is wider than 16 bits
//   the idle flag stands in for the core's idle state and is set by software
//   in pair mode the upper timer's own prescaler and pin are unused
`include "ctp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_pair
    import ctp_pkg::*;
(
    input  wire logic        clk,             // instruction clock, 25 MHz
    input  wire logic        reset,           // synchronous, active high
    input  wire logic [7:0]  address,         // avalon byte address
    input  wire logic        read,            // avalon read request
    input  wire logic        write,           // avalon write request
    input  wire logic [31:0] writedata,       // avalon write data
    input  wire logic [3:0]  byteenable,      // avalon byte lanes
    output logic      [31:0] readdata,        // avalon read data
    output logic             waitrequest,     // avalon stall
    output logic             response_error,  // unmapped address answered
    input  wire logic        ext_clock_low,   // external clock pin, lower timer
    input  wire logic        ext_clock_high,  // external clock pin, upper timer
    input  wire logic        gate_low,        // gate input, lower timer
    input  wire logic        gate_high,       // gate input, upper timer
    output logic             irq,             // level interrupt
    output logic             adc_trigger      // converter event pulse
);
    // registers
    ctp_word_type  lower_timer_control;
    ctp_word_type  upper_timer_control;
    ctp_word_type  count_low_word;
    ctp_word_type  count_high_word;
    ctp_word_type  period_low_word;
    ctp_word_type  period_high_word;
    ctp_word_type  count_high_hold;
    logic [2:0]    irq_status;
    logic [2:0]    irq_mask;
    logic          idle_mode;
    ctp_bus_state_type bus_state;

    // pin synchronisers, first stage read only by second
    logic [1:0] ext_sync1, ext_sync2, ext_prev;
    logic [1:0] gate_sync1, gate_sync2;
    logic [7:0] ps_count_low, ps_count_high;

    function automatic logic [7:0] ps_limit(input logic [1:0] sel);
        unique case (sel)
            2'b00: ps_limit = `CTP_DIV_1;
            2'b01: ps_limit = `CTP_DIV_8;
            2'b10: ps_limit = `CTP_DIV_64;
            2'b11: ps_limit = `CTP_DIV_256;
        endcase
    endfunction

    function automatic logic timer_enabled(input ctp_word_type ctl, input logic gate, input logic idle);
        // run bit, idle stop, gate only on internal clock
        timer_enabled = ctl[`CTP_BIT_RUN] && !(ctl[`CTP_BIT_IDLE_STOP] && idle)
                        && (ctl[`CTP_BIT_CLKSRC] || !ctl[`CTP_BIT_GATE] || gate);
    endfunction

    // both pins pass two flops before the edge detector reads them;
    // the third stage only delays the synchronised level for edge finding
    // reset clears every stage to the low idle level of the pins,
    // so no false rising edge is seen right after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_sync1  <= 2'h0;
            ext_sync2  <= 2'h0;
            ext_prev   <= 2'h0;
            gate_sync1 <= 2'h0;
            gate_sync2 <= 2'h0;
        end else begin
            ext_sync1  <= {ext_clock_high, ext_clock_low};
            ext_sync2  <= ext_sync1;
            ext_prev   <= ext_sync2;
            gate_sync1 <= {gate_high, gate_low};
            gate_sync2 <= gate_sync1;
        end
    end

    logic pair_mode;
    assign pair_mode = lower_timer_control[`CTP_BIT_PAIR];

    // source pulse: rising pin edge or every instruction clock
    logic [1:0] src_pulse;
    assign src_pulse[0] = lower_timer_control[`CTP_BIT_CLKSRC] ? (ext_sync2[0] & ~ext_prev[0]) : 1'b1;
    assign src_pulse[1] = upper_timer_control[`CTP_BIT_CLKSRC] ? (ext_sync2[1] & ~ext_prev[1]) : 1'b1;

    // pair mode uses lower clock and gate
    logic en_low, en_high;
    assign en_low  = timer_enabled(lower_timer_control, gate_sync2[0], idle_mode);
    // upper control only matters when not paired
    assign en_high = !pair_mode && timer_enabled(upper_timer_control, gate_sync2[1], idle_mode);

    // the prescaler counts source pulses, not clock cycles, so with the
    // external clock selected a ratio of 8 means eight pin rising edges
    // trade-off: clearing on stop loses a partly counted interval, but
    // makes the first tick after a start land at a known cycle
    // prescalers; counter cleared while stopped so a restart begins a fresh interval
    logic tick_low, tick_high;
    assign tick_low  = en_low && src_pulse[0] && (ps_count_low == ps_limit(lower_timer_control[5:4]));
    assign tick_high = en_high && src_pulse[1] && (ps_count_high == ps_limit(upper_timer_control[5:4]));

    always_ff @(posedge clk) begin
        if (reset || !en_low) begin
            ps_count_low <= 8'h00;
        end else if (src_pulse[0]) begin
            ps_count_low <= tick_low ? 8'h00 : ps_count_low + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !en_high) begin
            ps_count_high <= 8'h00;
        end else if (src_pulse[1]) begin
            ps_count_high <= tick_high ? 8'h00 : ps_count_high + 8'h01;
        end
    end

    // the pair compare needs both halves equal; the low half alone
    // would fire on every pass of the lower word through its period
    // matches, 32-bit when paired
    logic match_low, match_high, match_pair;
    assign match_low  = (count_low_word == period_low_word);
    assign match_high = (count_high_word == period_high_word);
    assign match_pair = match_low && match_high;

    // a request is acted on only in the idle state, so the request still
    // held during the completion cycle is not taken a second time
    // bus decode
    logic bus_wr, bus_rd, mapped;
    assign bus_wr = write && (bus_state == CTP_BUS_IDLE);
    assign bus_rd = read && (bus_state == CTP_BUS_IDLE);
    assign mapped = (address <= `CTP_OFF_IDLE) && (address[1:0] == 2'b00);

    function automatic ctp_word_type merge(input ctp_word_type old, input logic [31:0] wd, input logic [3:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // unimplemented bits are cut at the write, so reads need no mask;
    // the upper control keeps its bits in pair mode but they have no effect
    // stopping a timer and changing its prescale in one write is safe,
    // since the prescaler clears while the timer is stopped
    // control writes keep only implemented bits
    always_ff @(posedge clk) begin
        if (reset) begin
            lower_timer_control <= `CTP_CTRL_RESET;
            upper_timer_control <= `CTP_CTRL_RESET;
            period_low_word     <= `CTP_PERIOD_RESET;
            period_high_word    <= `CTP_PERIOD_RESET;
            irq_mask            <= 3'h0;
            idle_mode           <= 1'b0;
        end else if (bus_wr) begin
            case (address)
                `CTP_OFF_LOW_CTRL:    lower_timer_control <= merge(lower_timer_control, writedata, byteenable)
                                                             & `CTP_LOW_CTRL_MASK;
                `CTP_OFF_HIGH_CTRL:   upper_timer_control <= merge(upper_timer_control, writedata, byteenable)
                                                             & `CTP_HIGH_CTRL_MASK;
                `CTP_OFF_PERIOD_LOW:  period_low_word  <= merge(period_low_word, writedata, byteenable);
                `CTP_OFF_PERIOD_HIGH: period_high_word <= merge(period_high_word, writedata, byteenable);
                `CTP_OFF_IRQ_MASK:    if (byteenable[0]) irq_mask <= writedata[2:0];
                `CTP_OFF_IDLE:        if (byteenable[0]) idle_mode <= writedata[0];
                default: ;
            endcase
        end
    end

    // a software write of the hold register wins over the latch; both in one
    // cycle cannot happen, as only one request is served at a time
    // holding register written by software, latched on low-word read in pair mode
    always_ff @(posedge clk) begin
        if (reset) begin
            count_high_hold <= 16'h0000;
        end else if (bus_wr && address == `CTP_OFF_HOLD) begin
            count_high_hold <= merge(count_high_hold, writedata, byteenable);
        end else if (bus_rd && address == `CTP_OFF_COUNT_LOW && pair_mode) begin
            count_high_hold <= count_high_word;
        end
    end

    // limitation: a count written above the period runs on to all ones
    // and wraps through zero before the next match can occur
    // lower count; software write overrides a tick in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            count_low_word <= 16'h0000;
        end else if (bus_wr && address == `CTP_OFF_COUNT_LOW) begin
            count_low_word <= merge(count_low_word, writedata, byteenable);
        end else if (tick_low) begin
            // wrap to zero on match, else step by one
            if (pair_mode ? match_pair : match_low) begin
                count_low_word <= 16'h0000;
            end else begin
                count_low_word <= count_low_word + 16'h0001;
            end
        end
    end

    // in pair mode the carry comes from the lower word at all ones on a
    // lower tick; a load through the hold register sets both words at once
    // upper count carries the high word when paired
    always_ff @(posedge clk) begin
        if (reset) begin
            count_high_word <= 16'h0000;
        end else if (bus_wr && address == `CTP_OFF_COUNT_LOW && pair_mode) begin
            // hold plus low write loads both words together
            count_high_word <= count_high_hold;
        end else if (bus_wr && address == `CTP_OFF_COUNT_HIGH) begin
            count_high_word <= merge(count_high_word, writedata, byteenable);
        end else if (pair_mode) begin
            if (tick_low && match_pair) begin
                count_high_word <= 16'h0000;
            end else if (tick_low && count_low_word == 16'hFFFF) begin
                count_high_word <= count_high_word + 16'h0001;
            end
        end else if (tick_high) begin
            count_high_word <= match_high ? 16'h0000 : count_high_word + 16'h0001;
        end
    end

    // events are one-cycle strobes; the lower event is held off in pair
    // mode so software sees the pair match on one flag only
    // match events on the tick that wraps the count
    logic [2:0] irq_event;
    assign irq_event[`CTP_IRQ_LOW_MATCH]  = !pair_mode && tick_low && match_low;
    assign irq_event[`CTP_IRQ_HIGH_MATCH] = tick_high && match_high;
    // pair match reported on its own flag, bit 2
    assign irq_event[`CTP_IRQ_PAIR_MATCH] = pair_mode && tick_low && match_pair;

    // an event falling in the cycle of its own clear must not be lost,
    // otherwise a fast timer could drop an interrupt
    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_status <= 3'h0;
        end else if (bus_wr && address == `CTP_OFF_IRQ_STATUS && byteenable[0]) begin
            irq_status <= (irq_status & ~writedata[2:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    // level interrupt, one cycle behind the status so the pin is a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // the converter trigger is a one-cycle pulse per match and is not
    // gated by the interrupt mask
    // trigger only from the upper timer or the pair
    always_ff @(posedge clk) begin
        if (reset) begin
            adc_trigger <= 1'b0;
        end else begin
            adc_trigger <= irq_event[`CTP_IRQ_HIGH_MATCH] | irq_event[`CTP_IRQ_PAIR_MATCH];
        end
    end

    // the two-state machine keeps the bus answer fixed at one wait cycle,
    // whatever the address or direction
    // one wait cycle per access keeps read data from a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            bus_state <= CTP_BUS_IDLE;
        end else begin
            unique case (bus_state)
                CTP_BUS_IDLE: if (read || write) bus_state <= CTP_BUS_DONE;
                CTP_BUS_DONE: bus_state <= CTP_BUS_IDLE;
            endcase
        end
    end

    // waitrequest stands high while idle and drops only for the
    // completion cycle of a taken request
    always_ff @(posedge clk) begin
        if (reset) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(bus_state == CTP_BUS_IDLE && (read || write));
        end
    end

    // error flag updated at each taken request and held until the next
    always_ff @(posedge clk) begin
        if (reset) begin
            response_error <= 1'b0;
        end else if (bus_rd || bus_wr) begin
            response_error <= !mapped;
        end
    end

    // read mux; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (bus_rd) begin
            case (address)
                `CTP_OFF_LOW_CTRL:    readdata <= {16'h0000, lower_timer_control};
                `CTP_OFF_HIGH_CTRL:   readdata <= {16'h0000, upper_timer_control};
                `CTP_OFF_COUNT_LOW:   readdata <= {16'h0000, count_low_word};
                `CTP_OFF_COUNT_HIGH:  readdata <= {16'h0000, count_high_word};
                `CTP_OFF_PERIOD_LOW:  readdata <= {16'h0000, period_low_word};
                `CTP_OFF_PERIOD_HIGH: readdata <= {16'h0000, period_high_word};
                `CTP_OFF_HOLD:        readdata <= {16'h0000, count_high_hold};
                `CTP_OFF_IRQ_STATUS:  readdata <= {29'h0, irq_status};
                `CTP_OFF_IRQ_MASK:    readdata <= {29'h0, irq_mask};
                `CTP_OFF_IDLE:        readdata <= {31'h0, idle_mode};
                default:              readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: logic/ctp_consts.svh
// register offsets, field positions, reset values and timing counts of the timer pair
`ifndef CTP_CONSTS_SVH
`define CTP_CONSTS_SVH
`define CTP_OFF_LOW_CTRL    8'h00
`define CTP_OFF_HIGH_CTRL   8'h04
`define CTP_OFF_COUNT_LOW   8'h08
`define CTP_OFF_COUNT_HIGH  8'h0C
`define CTP_OFF_PERIOD_LOW  8'h10
`define CTP_OFF_PERIOD_HIGH 8'h14
`define CTP_OFF_HOLD        8'h18
`define CTP_OFF_IRQ_STATUS  8'h1C
`define CTP_OFF_IRQ_MASK    8'h20
`define CTP_OFF_IDLE        8'h24
`define CTP_BIT_RUN         15
`define CTP_BIT_IDLE_STOP   13
`define CTP_BIT_GATE        6
`define CTP_BIT_PS_HI       5
`define CTP_BIT_PS_LO       4
`define CTP_BIT_PAIR        3
`define CTP_BIT_CLKSRC      1
`define CTP_LOW_CTRL_MASK   16'hA07A
`define CTP_HIGH_CTRL_MASK  16'hA072
`define CTP_CTRL_RESET      16'h0000
`define CTP_PERIOD_RESET    16'hFFFF
`define CTP_IRQ_LOW_MATCH   0
`define CTP_IRQ_HIGH_MATCH  1
`define CTP_IRQ_PAIR_MATCH  2
`define CTP_IRQ_MASK_BITS   32'h0000_0007
`define CTP_DIV_1           8'h00
`define CTP_DIV_8           8'h07
`define CTP_DIV_64          8'h3F
`define CTP_DIV_256         8'hFF
`endif

// File: logic/ctp_pkg.sv
// types shared by the timer pair
package ctp_pkg;
    typedef logic [15:0] ctp_word_type;
    typedef logic [31:0] ctp_dword_type;
    typedef enum logic {CTP_BUS_IDLE, CTP_BUS_DONE} ctp_bus_state_type;
endpackage

// File: verif/ctp_timer_pair_asserts.sv
// bus timing and read-back checks of the timer pair
`include "ctp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_pair_asserts
    import ctp_pkg::*;
(
    input wire logic        clk,            // instruction clock
    input wire logic        reset,          // synchronous reset
    input wire logic [7:0]  address,        // bus address
    input wire logic        read,           // read request
    input wire logic        write,          // write request
    input wire logic [31:0] readdata,       // read data
    input wire logic        waitrequest,    // bus stall
    input wire logic        response_error  // unmapped access flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // a request and its completion, the two steps of every access
    sequence s_req; read || write; endsequence
    sequence s_done; !waitrequest; endsequence
    property p_done_soon; s_req |-> ##[0:2] s_done; endproperty
    property p_one_wait; s_done |=> waitrequest; endproperty
    property p_done_cause; s_done |-> $past(read || write); endproperty
    property p_err_unmapped;
        !waitrequest && read && address > 8'h24 |-> response_error && readdata == 32'h0000_0000;
    endproperty
    property p_err_mapped;
        !waitrequest && address <= 8'h24 && address[1:0] == 2'b00 |-> !response_error;
    endproperty
    property p_low_ctrl_zero;
        !waitrequest && read && address == `CTP_OFF_LOW_CTRL |-> (readdata & ~{16'h0000, `CTP_LOW_CTRL_MASK}) == 0;
    endproperty
    property p_high_ctrl_zero;
        !waitrequest && read && address == `CTP_OFF_HIGH_CTRL |-> (readdata & ~{16'h0000, `CTP_HIGH_CTRL_MASK}) == 0;
    endproperty
    // read data may only move when a read completes
    property p_read_hold; $changed(readdata) |-> read && !waitrequest; endproperty
    a_done_soon: assert property (p_done_soon) else $error("access not completed in time");
    a_one_wait: assert property (p_one_wait) else $error("completion longer than one cycle");
    a_done_cause: assert property (p_done_cause) else $error("completion without request");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access flagged");
    a_low_ctrl_zero: assert property (p_low_ctrl_zero) else $error("lower control spare bit set");
    a_high_ctrl_zero: assert property (p_high_ctrl_zero) else $error("upper control spare bit set");
    a_read_hold: assert property (p_read_hold) else $error("read data moved outside a read");
endmodule
bind ctp_timer_pair ctp_timer_pair_asserts u_chk (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest), .response_error(response_error));
`default_nettype wire

// File: verif/tb_ctp_timer_pair.sv
// self-checking bench of the cascadable timer pair
`include "ctp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end
module tb_ctp_timer_pair import ctp_pkg::*;;
    logic          clk = 1'b0;
    logic          reset = 1'b1;
    logic [7:0]    address = 8'h00;
    logic          read = 1'b0;
    logic          write = 1'b0;
    ctp_dword_type writedata = 32'h0000_0000;
    ctp_dword_type readdata;
    logic          waitrequest, response_error, irq, adc_trigger;
    logic          ext_clock_low = 1'b0, ext_clock_high = 1'b0, gate_low = 1'b0, gate_high = 1'b0;
    int            bad_count = 0, total_checks = 0, cycles = 0;
    logic [15:0]   lfsr = 16'hEAD9;
    ctp_dword_type exp_q[$], msk_q[$];
    ctp_dword_type e, m;
    ctp_timer_pair u_dut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .response_error(response_error), .ext_clock_low(ext_clock_low), .ext_clock_high(ext_clock_high),
        .gate_low(gate_low), .gate_high(gate_high), .irq(irq), .adc_trigger(adc_trigger));
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    initial forever #20 clk = ~clk;
    // noise on the unused lower pins; upper pin rises every fourth cycle
    always @(posedge clk) begin
        cycles++;
        lfsr <= lfsr_next(lfsr);
        gate_low <= lfsr[0];
        ext_clock_low <= lfsr[3];
        ext_clock_high <= cycles[1];
        if (cycles == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // every completed read is matched against the oldest note
    always @(posedge clk) begin
        if (read && !waitrequest && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK(readdata & m, e)
        end
    end
    task automatic bus(input logic wr, input logic [7:0] a, input ctp_dword_type d);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input ctp_word_type d);
        bus(1'b1, a, {16'h0000, d});
    endtask
    task automatic rd(input logic [7:0] a, input ctp_dword_type x, input ctp_dword_type k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // stop, clear the count, load the period, then run with the new control
    task automatic start(input logic [7:0] c, input logic [7:0] n, input logic [7:0] p, input ctp_word_type cv);
        wr(c, 16'h0000);
        wr(n, 16'h0000);
        wr(p, 16'h0002);
        wr(c, cv);
    endtask
    // cycles between two trigger pulses, 0 when none comes within 1000 cycles
    task automatic gap(input int x);
        int n;
        int k;
        n = 0;
        k = 0;
        while (!adc_trigger && k < 1000) begin
            k++;
            @(posedge clk);
        end
        if (k < 1000) do begin
            @(posedge clk);
            n++;
        end while (!adc_trigger && n < 2000);
        `CHK(n, x)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        ctp_word_type v;
        int div [4] = '{1, 8, 64, 256};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(`CTP_OFF_LOW_CTRL, 32'h0, 32'hFFFF_FFFF);
        rd(`CTP_OFF_PERIOD_HIGH, 32'hFFFF, 32'hFFFF_FFFF);
        rd(8'h28, 32'h0, 32'hFFFF_FFFF);
        // random control words with the run bit kept clear
        for (int i = 0; i < 4; i++) begin
            v = lfsr & 16'h7FFF;
            wr(`CTP_OFF_LOW_CTRL, v);
            wr(`CTP_OFF_HIGH_CTRL, v);
            rd(`CTP_OFF_LOW_CTRL, {16'h0, v & `CTP_LOW_CTRL_MASK}, 32'hFFFF_FFFF);
            rd(`CTP_OFF_HIGH_CTRL, {16'h0, v & `CTP_HIGH_CTRL_MASK}, 32'hFFFF_FFFF);
        end
        wr(`CTP_OFF_LOW_CTRL, 16'h0000);
        // upper timer alone, period 2, every prescale ratio
        for (int p = 0; p < 4; p++) begin
            start(`CTP_OFF_HIGH_CTRL, `CTP_OFF_COUNT_HIGH, `CTP_OFF_PERIOD_HIGH, {8'h80, 2'b00, p[1:0], 4'h0});
            gap(3 * div[p]);
        end
        wr(`CTP_OFF_IDLE, 16'h0001);
        start(`CTP_OFF_HIGH_CTRL, `CTP_OFF_COUNT_HIGH, `CTP_OFF_PERIOD_HIGH, 16'hA000);
        gap(0);
        start(`CTP_OFF_HIGH_CTRL, `CTP_OFF_COUNT_HIGH, `CTP_OFF_PERIOD_HIGH, 16'h8000);
        gap(3);
        wr(`CTP_OFF_IDLE, 16'h0000);
        start(`CTP_OFF_HIGH_CTRL, `CTP_OFF_COUNT_HIGH, `CTP_OFF_PERIOD_HIGH, 16'h8040);
        gap(0);
        gate_high <= 1'b1;
        gap(3);
        gate_high <= 1'b0;
        start(`CTP_OFF_HIGH_CTRL, `CTP_OFF_COUNT_HIGH, `CTP_OFF_PERIOD_HIGH, 16'h8042);
        gap(12);
        wr(`CTP_OFF_HIGH_CTRL, 16'h0000);
        start(`CTP_OFF_LOW_CTRL, `CTP_OFF_COUNT_LOW, `CTP_OFF_PERIOD_LOW, 16'h8000);
        gap(0);
        wr(`CTP_OFF_LOW_CTRL, 16'h0000);
        // masked, unmasked, then cleared upper match
        wr(`CTP_OFF_IRQ_MASK, 16'h0000);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(`CTP_OFF_IRQ_MASK, 16'h0002);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(`CTP_OFF_IRQ_STATUS, 16'h0007);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        rd(`CTP_OFF_IRQ_STATUS, 32'h0, 32'h7);
        // pair mode first, ignored upper control, 32-bit period 5
        // software order: pair mode, setup, periods, run bit last
        wr(`CTP_OFF_LOW_CTRL, 16'h0008);
        wr(`CTP_OFF_HIGH_CTRL, 16'h8030);
        wr(`CTP_OFF_PERIOD_HIGH, 16'h0000);
        wr(`CTP_OFF_HOLD, 16'h0000);
        wr(`CTP_OFF_COUNT_LOW, 16'h0000);
        wr(`CTP_OFF_PERIOD_LOW, 16'h0005);
        wr(`CTP_OFF_LOW_CTRL, 16'h8008);
        gap(6);
        rd(`CTP_OFF_IRQ_STATUS, 32'h4, 32'h5);
        // stopped pair loads both words together
        wr(`CTP_OFF_LOW_CTRL, 16'h0008);
        wr(`CTP_OFF_HOLD, 16'h0003);
        wr(`CTP_OFF_COUNT_LOW, 16'h0007);
        rd(`CTP_OFF_COUNT_HIGH, 32'h3, 32'hFFFF_FFFF);
        rd(`CTP_OFF_COUNT_LOW, 32'h7, 32'hFFFF_FFFF);
        rd(`CTP_OFF_HOLD, 32'h3, 32'hFFFF_FFFF);
        report_and_stop();
    end
endmodule
`default_nettype wire
